/* File: design/dacs_channel.sv */
// Functional notes
// - status bit 0 reads 1 when the sample FIFO is empty
// - status bit 1 reads 1 when occupancy is half of capacity or less
// - status bit 2 reads 1 when the FIFO is at full capacity
// - bit 3 set on fetch from empty FIFO, cleared by writing 1
// - bit 4 reads 0 during a burst, set at last sample, write 1 clears
// - status bit 5 reads 1 while a serial transfer is underway
// - direct write launches serial shift of command and data, about 2.5 us
// - busy rises at the direct write and stays high until the shift ends
// - direct path gives no readback of converter registers
// - word bits 15-0 are data, bits 19-16 the command code
// - code 0001 loads the input register only
// - code 0010 copies input register to output register
// - code 0011 loads input and output together
// - code 0100 writes the converter control register
// - code 0111 data reset to level chosen by the power-up bits
// - code 1001 disables chaining, floats unused serial output
// - code 1111 fully resets the converter to power-up state
// - codes 0,5,6,d,e do nothing; 8 reserved; a,b unsupported
// - channel clear forces empty and half flags to 1, full to 0
`timescale 1ns/100ps
`include "dacs_consts.svh"
module dacs_channel (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // register bus
   input wire dacs_pkg::dacs_apb_req_t apb_req,
   output dacs_pkg::dacs_apb_rsp_t apb_rsp,
   // sequencer side
   input wire dacs_pkg::dacs_fifo_t fifo,
   input wire dacs_pkg::dacs_seq_evt_t seq_evt,
   // converter shadow
   output logic powerup_level_sel_hi,
   output logic powerup_level_sel_lo,
   output dacs_pkg::dacs_cmd_t last_cmd,
   // converter pins
   output dacs_pkg::dacs_ser_t dac_pins
);
   // ==================================================
   // helpers
   function automatic dacs_pkg::dacs_asel_t addr_sel(input logic [11:0] a);
      dacs_pkg::dacs_asel_t r;
      if (a == `DACS_STATUS_OFFS) begin
         r = dacs_pkg::DACS_A_STATUS;
      end else if (a == `DACS_DIRECT_OFFS) begin
         r = dacs_pkg::DACS_A_DIRECT;
      end else begin
         r = dacs_pkg::DACS_A_NONE;
      end
      return r;
   endfunction

   function automatic dacs_pkg::dacs_cmd_t cmd_class(input logic [3:0] c);
      dacs_pkg::dacs_cmd_t r;
      case (c)
         `DACS_CMD_LOAD_IN: begin
            r = dacs_pkg::DACS_C_LOAD_IN;
         end
         `DACS_CMD_UPDATE: begin
            r = dacs_pkg::DACS_C_UPDATE;
         end
         `DACS_CMD_LOAD_UPD: begin
            r = dacs_pkg::DACS_C_LOAD_UPD;
         end
         `DACS_CMD_CTRL: begin
            r = dacs_pkg::DACS_C_CTRL;
         end
         `DACS_CMD_DRESET: begin
            r = dacs_pkg::DACS_C_DRESET;
         end
         `DACS_CMD_NOCHAIN: begin
            r = dacs_pkg::DACS_C_NOCHAIN;
         end
         `DACS_CMD_FRESET: begin
            r = dacs_pkg::DACS_C_FRESET;
         end
         `DACS_CMD_RSVD,
         `DACS_CMD_RD_IN,
         `DACS_CMD_RD_DAC: begin
            r = dacs_pkg::DACS_C_REFUSE;
         end
         default: begin
            r = dacs_pkg::DACS_C_NOP;
         end
      endcase
      return r;
   endfunction

   // ==================================================
   // state and wires
   dacs_pkg::dacs_main_st_t s;
   dacs_pkg::dacs_main_st_t next_s;
   logic tick;
   logic sh_busy;
   logic busy;
   logic setup;
   logic wr;
   logic fifo_empty;
   logic fifo_half;
   logic fifo_full;
   logic [31:0] status_word;
   logic [31:0] wdata;
   dacs_pkg::dacs_asel_t sel;
   dacs_pkg::dacs_cmd_t cls;

   // ==================================================
   // bit rate divider and serial shifter
   dacs_div u_div (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick)
   );

   dacs_shift u_shift (
      .pclk(pclk),
      .presetn(presetn),
      .start(s.start),
      .frame(s.frame),
      .tick(tick),
      .busy(sh_busy),
      .pins(dac_pins)
   );

   // ==================================================
   // bus decode
   assign sel = addr_sel(apb_req.paddr);
   assign setup = apb_req.psel & ~apb_req.penable;
   assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
   assign wdata = apb_req.pwdata;
   assign cls = cmd_class(wdata[`DACS_CMD_MSB:`DACS_CMD_LSB]);

   // one access cycle, error on unmapped addresses
   always_comb begin
      apb_rsp.prdata = s.prdata;
      apb_rsp.pready = apb_req.psel & apb_req.penable;
      apb_rsp.pslverr = apb_req.psel & apb_req.penable & (sel == dacs_pkg::DACS_A_NONE);
   end

   // ==================================================
   // FIFO flags
   always_comb begin
      if (seq_evt.clear) begin
         fifo_empty = 1'b1;
         fifo_half = 1'b1;
         fifo_full = 1'b0;
      end else begin
         fifo_empty = (fifo.level == 17'h00000);
         fifo_half = ({fifo.level, 1'b0} <= {1'b0, fifo.depth});
         fifo_full = (fifo.level >= fifo.depth);
      end
   end

   // shift running, request pending or minimum hold
   assign busy = s.start | sh_busy | (s.hold != 5'd0);

   always_comb begin
      status_word = 32'h00000000;
      status_word[`DACS_ST_EMPTY] = fifo_empty;
      status_word[`DACS_ST_HALF] = fifo_half;
      status_word[`DACS_ST_FULL] = fifo_full;
      status_word[`DACS_ST_UNDER] = s.underflow;
      status_word[`DACS_ST_BURST] = s.burst_done;
      status_word[`DACS_ST_BUSY] = busy;
   end

   // ==================================================
   // next state
   always_comb begin
      next_s = s;
      next_s.start = 1'b0;

      // read data captured in the setup cycle
      if (setup) begin
         if (sel == dacs_pkg::DACS_A_STATUS) begin
            next_s.prdata = status_word;
         end else begin
            next_s.prdata = 32'h00000000;
         end
      end

      if (s.hold != 5'd0) begin
         next_s.hold = s.hold - 5'd1;
      end

      // sticky flags, the hardware set wins over the host clear
      if (wr && sel == dacs_pkg::DACS_A_STATUS) begin
         if (wdata[`DACS_ST_UNDER]) begin
            next_s.underflow = 1'b0;
         end
         if (wdata[`DACS_ST_BURST]) begin
            next_s.burst_done = 1'b0;
         end
      end
      if (seq_evt.burst_start) begin
         next_s.burst_done = 1'b0;
      end
      if (seq_evt.underflow) begin
         next_s.underflow = 1'b1;
      end
      if (seq_evt.burst_done) begin
         next_s.burst_done = 1'b1;
      end

      // direct command, dropped while a transfer is still running
      if (wr && sel == dacs_pkg::DACS_A_DIRECT && !busy) begin
         next_s.last_cmd = cls;
         if (cls != dacs_pkg::DACS_C_REFUSE) begin
            next_s.start = 1'b1;
            next_s.hold = 5'(`DACS_XFER_CYCLES);
            next_s.frame = {4'h0, wdata[`DACS_CMD_MSB:`DACS_CMD_LSB],
                            wdata[`DACS_DATA_MSB:0]};
         end
         if (cls == dacs_pkg::DACS_C_CTRL) begin
            next_s.pv_hi = wdata[`DACS_PV_HI_BIT];
            next_s.pv_lo = wdata[`DACS_PV_LO_BIT];
         end
         if (cls == dacs_pkg::DACS_C_FRESET) begin
            next_s.pv_hi = `DACS_PV_RST;
            next_s.pv_lo = `DACS_PV_RST;
         end
      end
   end

   // ==================================================
   // registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '{underflow: `DACS_UNDER_RST,
                burst_done: `DACS_BURST_RST,
                start: 1'b0,
                frame: 24'h000000,
                hold: 5'd0,
                pv_hi: `DACS_PV_RST,
                pv_lo: `DACS_PV_RST,
                last_cmd: dacs_pkg::DACS_C_NOP,
                prdata: 32'h00000000};
      end else begin
         s <= next_s;
      end
   end

   // ==================================================
   // outputs
   assign powerup_level_sel_hi = s.pv_hi;
   assign powerup_level_sel_lo = s.pv_lo;
   assign last_cmd = s.last_cmd;
endmodule

/* File: common/dacs_consts.svh */
`ifndef DACS_CONSTS_SVH
`define DACS_CONSTS_SVH
// ==================================================
// register offsets
`define DACS_STATUS_OFFS 12'h014
`define DACS_DIRECT_OFFS 12'h018
// ==================================================
// status fields
`define DACS_ST_EMPTY 0
`define DACS_ST_HALF 1
`define DACS_ST_FULL 2
`define DACS_ST_UNDER 3
`define DACS_ST_BURST 4
`define DACS_ST_BUSY 5
`define DACS_UNDER_RST 1'b0
`define DACS_BURST_RST 1'b0
// ==================================================
// direct command fields
`define DACS_DATA_MSB 15
`define DACS_CMD_MSB 19
`define DACS_CMD_LSB 16
`define DACS_MBZ_BIT 20
`define DACS_PV_HI_BIT 4
`define DACS_PV_LO_BIT 3
`define DACS_PV_RST 1'b0
// ==================================================
// command codes
`define DACS_CMD_NOP0 4'h0
`define DACS_CMD_LOAD_IN 4'h1
`define DACS_CMD_UPDATE 4'h2
`define DACS_CMD_LOAD_UPD 4'h3
`define DACS_CMD_CTRL 4'h4
`define DACS_CMD_NOP5 4'h5
`define DACS_CMD_NOP6 4'h6
`define DACS_CMD_DRESET 4'h7
`define DACS_CMD_RSVD 4'h8
`define DACS_CMD_NOCHAIN 4'h9
`define DACS_CMD_RD_IN 4'ha
`define DACS_CMD_RD_DAC 4'hb
`define DACS_CMD_NOPD 4'hd
`define DACS_CMD_NOPE 4'he
`define DACS_CMD_FRESET 4'hf
// ==================================================
// timing
`define DACS_CLK_NS 50
`define DACS_XFER_NS 1000
`define DACS_XFER_CYCLES ((`DACS_XFER_NS + `DACS_CLK_NS - 1) / `DACS_CLK_NS)
`define DACS_SCLK_DIV 2'd1
`define DACS_FRAME_BITS 5'd24
`endif

/* File: common/dacs_pkg.sv */
package dacs_pkg;
   // ==================================================
   // carriers
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } dacs_apb_req_t;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } dacs_apb_rsp_t;
   typedef struct packed {
      logic sclk;
      logic sync_n;
      logic sdo;
   } dacs_ser_t;
   typedef struct packed {
      logic [16:0] level;
      logic [16:0] depth;
   } dacs_fifo_t;
   typedef struct packed {
      logic underflow;
      logic burst_start;
      logic burst_done;
      logic clear;
   } dacs_seq_evt_t;
   // ==================================================
   // enumerations
   typedef enum logic [3:0] {
      DACS_C_NOP,
      DACS_C_LOAD_IN,
      DACS_C_UPDATE,
      DACS_C_LOAD_UPD,
      DACS_C_CTRL,
      DACS_C_DRESET,
      DACS_C_NOCHAIN,
      DACS_C_FRESET,
      DACS_C_REFUSE
   } dacs_cmd_t;
   typedef enum logic [1:0] {
      DACS_S_IDLE,
      DACS_S_HIGH,
      DACS_S_LOW,
      DACS_S_END
   } dacs_sh_state_t;
   typedef enum logic [1:0] {
      DACS_A_NONE,
      DACS_A_STATUS,
      DACS_A_DIRECT
   } dacs_asel_t;
   // ==================================================
   // module state
   typedef struct packed {
      logic [1:0] cnt;
   } dacs_div_st_t;
   typedef struct packed {
      dacs_sh_state_t state;
      logic [23:0] sr;
      logic [4:0] bits;
      dacs_ser_t pins;
   } dacs_sh_st_t;
   typedef struct packed {
      logic underflow;
      logic burst_done;
      logic start;
      logic [23:0] frame;
      logic [4:0] hold;
      logic pv_hi;
      logic pv_lo;
      dacs_cmd_t last_cmd;
      logic [31:0] prdata;
   } dacs_main_st_t;
endpackage

/* File: design/dacs_div.sv */
`timescale 1ns/100ps
`include "dacs_consts.svh"
module dacs_div (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // bit rate enable
   output logic tick
);
   dacs_pkg::dacs_div_st_t s;
   dacs_pkg::dacs_div_st_t next_s;

   always_comb begin
      next_s = s;
      tick = 1'b0;
      if (s.cnt == `DACS_SCLK_DIV - 2'd1) begin
         next_s.cnt = 2'd0;
         tick = 1'b1;
      end else begin
         next_s.cnt = s.cnt + 2'd1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule

/* File: design/dacs_shift.sv */
`timescale 1ns/100ps
`include "dacs_consts.svh"
module dacs_shift (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // request
   input wire logic start,
   input wire logic [23:0] frame,
   input wire logic tick,
   output logic busy,
   // converter pins
   output dacs_pkg::dacs_ser_t pins
);
   dacs_pkg::dacs_sh_st_t s;
   dacs_pkg::dacs_sh_st_t next_s;

   assign busy = (s.state != dacs_pkg::DACS_S_IDLE);
   assign pins = s.pins;

   // ==================================================
   // frame sequencer, msb first, converter samples on sclk fall
   always_comb begin
      next_s = s;
      case (s.state)
         dacs_pkg::DACS_S_IDLE: begin
            if (start) begin
               next_s.sr = frame;
               next_s.bits = 5'd0;
               next_s.pins.sync_n = 1'b0;
               next_s.state = dacs_pkg::DACS_S_HIGH;
            end
         end
         dacs_pkg::DACS_S_HIGH: begin
            if (tick) begin
               next_s.pins.sclk = 1'b1;
               next_s.pins.sdo = s.sr[23];
               next_s.state = dacs_pkg::DACS_S_LOW;
            end
         end
         dacs_pkg::DACS_S_LOW: begin
            if (tick) begin
               next_s.pins.sclk = 1'b0;
               next_s.sr = {s.sr[22:0], 1'b0};
               next_s.bits = s.bits + 5'd1;
               if (s.bits == `DACS_FRAME_BITS - 5'd1) begin
                  next_s.state = dacs_pkg::DACS_S_END;
               end else begin
                  next_s.state = dacs_pkg::DACS_S_HIGH;
               end
            end
         end
         default: begin
            if (tick) begin
               next_s.pins.sync_n = 1'b1;
               next_s.pins.sdo = 1'b0;
               next_s.state = dacs_pkg::DACS_S_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '{state: dacs_pkg::DACS_S_IDLE, sr: 24'h000000, bits: 5'd0,
                pins: '{sclk: 1'b0, sync_n: 1'b1, sdo: 1'b0}};
      end else begin
         s <= next_s;
      end
   end
endmodule

/* File: sim/dacs_channel_checker.sv */
`timescale 1ns/100ps
`include "dacs_consts.svh"
module dacs_channel_checker (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // register bus
   input wire dacs_pkg::dacs_apb_req_t apb_req,
   input wire dacs_pkg::dacs_apb_rsp_t apb_rsp,
   // sequencer side
   input wire dacs_pkg::dacs_fifo_t fifo,
   input wire dacs_pkg::dacs_seq_evt_t seq_evt,
   // converter pins
   input wire dacs_pkg::dacs_ser_t dac_pins
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic acc;
   logic rd_st;
   logic rd_dir;
   assign acc = apb_req.psel & apb_req.penable;
   assign rd_st = acc & !apb_req.pwrite & (apb_req.paddr == `DACS_STATUS_OFFS);
   assign rd_dir = acc & !apb_req.pwrite & (apb_req.paddr == `DACS_DIRECT_OFFS);
   // ==================================================
   // status word, captured in the setup cycle
   AST_EMPTY: assert property (rd_st |-> apb_rsp.prdata[0] == ($past(fifo.level) == 0 || $past(seq_evt.clear)))
      else $error("empty flag wrong");
   AST_HALF: assert property (rd_st |-> apb_rsp.prdata[1] ==
      ($past(seq_evt.clear) || $past(fifo.level) * 2 <= $past(fifo.depth))) else $error("half flag wrong");
   AST_FULL: assert property (rd_st |-> apb_rsp.prdata[2] ==
      (!$past(seq_evt.clear) && $past(fifo.level) >= $past(fifo.depth))) else $error("full flag wrong");
   AST_BUSY: assert property (rd_st && $past(!dac_pins.sync_n) |-> apb_rsp.prdata[5])
      else $error("busy low during frame");
   AST_RSVD: assert property (rd_st |-> apb_rsp.prdata[31:6] == 26'h0)
      else $error("reserved status bits set");
   AST_NORB: assert property (rd_dir |-> apb_rsp.prdata == 32'h0)
      else $error("direct register read back");
   AST_ERR: assert property (acc |-> apb_rsp.pslverr == !(apb_req.paddr inside {12'h014, 12'h018}))
      else $error("slave error wrong");
   // ==================================================
   // serial frame
   AST_LAUNCH: assert property ($fell(dac_pins.sync_n) |->
      $past(acc && apb_req.pwrite && apb_req.paddr == `DACS_DIRECT_OFFS, 2)) else $error("frame without write");
   AST_FRAME: assert property ($fell(dac_pins.sync_n) |->
      !dac_pins.sclk ##1 dac_pins.sclk ##1 !dac_pins.sclk ##46 !dac_pins.sync_n ##1 dac_pins.sync_n)
      else $error("frame timing wrong");
   AST_HDR: assert property ($fell(dac_pins.sync_n) |->
      ##1 !dac_pins.sdo ##2 !dac_pins.sdo ##2 !dac_pins.sdo ##2 !dac_pins.sdo) else $error("header bits set");
   AST_SDO: assert property (dac_pins.sclk |=> $stable(dac_pins.sdo))
      else $error("data moved at falling clock");
   AST_IDLE: assert property (dac_pins.sync_n && $past(dac_pins.sync_n) |-> !dac_pins.sclk && !dac_pins.sdo)
      else $error("pins active while idle");
endmodule

/* File: sim/dacs_conv_model.sv */
`timescale 1ns/100ps
module dacs_conv_model (
   // converter pins
   input wire dacs_pkg::dacs_ser_t pins,
   // decoded state
   output logic [23:0] frame,
   output logic [15:0] out_reg,
   output int frames
);
   logic [23:0] sr = 24'h0;
   logic [15:0] in_reg = 16'h0;
   logic [15:0] ctrl = 16'h0;
   int nbits = 0;
   initial begin
      frame = 24'h0;
      out_reg = 16'h0;
      frames = 0;
   end
   // samples on the falling clock edge
   always @(negedge pins.sclk) begin
      sr = {sr[22:0], pins.sdo};
      nbits++;
   end
   always @(negedge pins.sync_n) nbits = 0;
   // short frames are dropped
   always @(posedge pins.sync_n) begin
      if (nbits == 24) begin
         frame = sr;
         frames++;
         case (sr[19:16])
            4'h1: in_reg = sr[15:0];
            4'h2: out_reg = in_reg;
            4'h3: {in_reg, out_reg} = {2{sr[15:0]}};
            4'h4: ctrl = sr[15:0];
            4'h7: out_reg = ctrl[4] ? 16'hffff : {ctrl[3], 15'h0};
            4'hf: {in_reg, out_reg, ctrl} = 48'h0;
            default: ;
         endcase
      end
   end
endmodule

/* File: sim/dacs_channel_tb.sv */
`timescale 1ns/100ps
`include "dacs_consts.svh"
module dacs_channel_tb;
   typedef struct packed {
      logic [16:0] level;
      logic [16:0] depth;
      logic clr;
      logic [2:0] flags;
   } dacs_st_row_t;
   typedef struct packed {
      logic [3:0] code;
      logic [15:0] data;
      logic [15:0] out;
      logic [1:0] pv;
      logic [3:0] cls;
   } dacs_cmd_row_t;
   // flags are {full, half, empty}
   localparam dacs_st_row_t ST_ROWS [7] = '{'{0, 64, 0, 3'b011}, '{1, 64, 0, 3'b010}, '{32, 64, 0, 3'b010},
      '{33, 64, 0, 3'b000}, '{64, 64, 0, 3'b100}, '{64, 64, 1, 3'b011}, '{0, 1, 0, 3'b011}};
   // cls follows dacs_cmd_t order
   localparam dacs_cmd_row_t CMD_ROWS [17] = '{'{4, 16'h0008, 0, 1, 4}, '{1, 16'h1234, 0, 1, 1},
      '{2, 0, 16'h1234, 1, 2}, '{3, 16'habcd, 16'habcd, 1, 3}, '{7, 0, 16'h8000, 1, 5},
      '{0, 16'hffff, 16'h8000, 1, 0}, '{5, 16'hffff, 16'h8000, 1, 0}, '{6, 16'hffff, 16'h8000, 1, 0},
      '{13, 16'hffff, 16'h8000, 1, 0}, '{14, 16'hffff, 16'h8000, 1, 0}, '{9, 0, 16'h8000, 1, 6},
      '{8, 16'hffff, 16'h8000, 1, 8}, '{10, 16'hffff, 16'h8000, 1, 8}, '{11, 16'hffff, 16'h8000, 1, 8},
      '{4, 16'h0010, 16'h8000, 2, 4}, '{7, 0, 16'hffff, 2, 5}, '{15, 0, 0, 0, 7}};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   dacs_pkg::dacs_apb_req_t req = '0;
   dacs_pkg::dacs_apb_rsp_t rsp;
   dacs_pkg::dacs_fifo_t fifo = {17'd0, 17'd64};
   dacs_pkg::dacs_seq_evt_t evt = '0;
   logic pv_hi;
   logic pv_lo;
   dacs_pkg::dacs_cmd_t cls;
   dacs_pkg::dacs_ser_t pins;
   logic [23:0] frame;
   logic [15:0] out_reg;
   int frames;
   int num_errors = 0;
   int check_count = 0;
   logic [31:0] rd;
   logic err;
   always #25 pclk = ~pclk;
   dacs_channel u_dacs_channel (
      .pclk(pclk),
      .presetn(presetn),
      .apb_req(req),
      .apb_rsp(rsp),
      .fifo(fifo),
      .seq_evt(evt),
      .powerup_level_sel_hi(pv_hi),
      .powerup_level_sel_lo(pv_lo),
      .last_cmd(cls),
      .dac_pins(pins)
   );
   dacs_conv_model u_dacs_conv_model (
      .pins(pins),
      .frame(frame),
      .out_reg(out_reg),
      .frames(frames)
   );
   // ==================================================
   // tasks
   task automatic wrap_up();
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      req <= '{1'b1, 1'b0, wr, a, d};
      @(posedge pclk);
      req.penable <= 1'b1;
      @(posedge pclk);
      while (rsp.pready !== 1'b1) begin
         n++;
         if (n > 16) begin
            chk(0, 1, "bus timeout");
            wrap_up();
         end
         @(posedge pclk);
      end
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic st(input logic wr, input logic [31:0] d, input logic [31:0] exp);
      if (wr) apb(1'b1, `DACS_STATUS_OFFS, d);
      apb(1'b0, `DACS_STATUS_OFFS, 32'h0);
      chk(rd, exp, "status word");
   endtask
   task automatic pulse(input dacs_pkg::dacs_seq_evt_t e);
      evt <= e;
      @(posedge pclk);
      evt <= '0;
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         apb(1'b0, `DACS_STATUS_OFFS, 32'h0);
         n++;
      end while (rd[5] !== 1'b0 && n < 40);
      if (n >= 40) begin
         chk(0, 1, "busy timeout");
         wrap_up();
      end
   endtask
   // ==================================================
   // main sequence
   initial begin
      logic refused;
      int n0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({pins, pv_hi, pv_lo}, 5'b01000, "pins or shadow after reset");
      chk(cls, dacs_pkg::DACS_C_NOP, "class after reset");
      st(1'b0, 32'h0, 32'h3);
      foreach (ST_ROWS[i]) begin
         fifo <= {ST_ROWS[i].level, ST_ROWS[i].depth};
         evt.clear <= ST_ROWS[i].clr;
         st(1'b0, 32'h0, {29'h0, ST_ROWS[i].flags});
      end
      fifo <= {17'd0, 17'd64};
      evt <= '0;
      @(posedge pclk);
      pulse(4'b1010);
      st(1'b0, 32'h0, 32'h1b);
      st(1'b1, 32'h0, 32'h1b);
      st(1'b1, 32'hffffffe7, 32'h1b);
      st(1'b1, 32'h8, 32'h13);
      st(1'b1, 32'h10, 32'h3);
      pulse(4'b0010);
      st(1'b0, 32'h0, 32'h13);
      pulse(4'b0100);
      st(1'b0, 32'h0, 32'h3);
      foreach (CMD_ROWS[i]) begin
         n0 = frames;
         refused = CMD_ROWS[i].cls == 4'd8;
         apb(1'b1, `DACS_DIRECT_OFFS, {12'h0, CMD_ROWS[i].code, CMD_ROWS[i].data});
         apb(1'b0, `DACS_STATUS_OFFS, 32'h0);
         chk(rd[5], !refused, "busy after direct write");
         wait_idle();
         chk(frames - n0, !refused, "frame count");
         if (!refused) chk(frame, {4'h0, CMD_ROWS[i].code, CMD_ROWS[i].data}, "frame bits");
         chk(out_reg, CMD_ROWS[i].out, "converter output");
         chk({pv_hi, pv_lo}, CMD_ROWS[i].pv, "power-up shadow");
         chk(cls, CMD_ROWS[i].cls, "command class");
      end
      n0 = frames;
      apb(1'b1, `DACS_DIRECT_OFFS, 32'h0001_5555);
      apb(1'b1, `DACS_DIRECT_OFFS, 32'h0003_7777);
      wait_idle();
      chk(frames - n0, 1, "write during busy");
      chk(frame, 24'h015555, "frame kept");
      chk(cls, dacs_pkg::DACS_C_LOAD_IN, "class kept");
      apb(1'b0, 12'h01c, 32'h0);
      chk(err, 1'b1, "unmapped read");
      apb(1'b1, 12'h010, 32'hffffffff);
      chk(err, 1'b1, "unmapped write");
      apb(1'b0, `DACS_DIRECT_OFFS, 32'hffffffff);
      chk(err, 1'b0, "direct read error");
      chk(rd, 32'h0, "direct read data");
      // reset in mid-frame, then the bus and link start clean
      n0 = frames;
      pulse(4'b1000);
      apb(1'b1, `DACS_DIRECT_OFFS, 32'h0004_0018);
      repeat (6) @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({pins, pv_hi, pv_lo}, 5'b01000, "pins or shadow after mid-run reset");
      chk(cls, dacs_pkg::DACS_C_NOP, "class after mid-run reset");
      chk(frames - n0, 0, "cut frame dropped");
      st(1'b0, 32'h0, 32'h3);
      wrap_up();
   end
endmodule
bind dacs_channel dacs_channel_checker u_dacs_channel_checker (
   .pclk(pclk),
   .presetn(presetn),
   .apb_req(apb_req),
   .apb_rsp(apb_rsp),
   .fifo(fifo),
   .seq_evt(seq_evt),
   .dac_pins(dac_pins)
);
